// File: testbench/ecm_checker.sv
// concurrent checks on the compare-match array ports
`timescale 1ns/10ps
`default_nettype none
module ecm_checker
	import ecm_pkg::*;
#(
	parameter int NUM_CHAN = ECM_NUM_CHAN,
	parameter int TW = ECM_TIMER_W,
	parameter ecm_variant_t VARIANT = ECM_FULL
)(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// timers and channels
	input wire logic [ECM_NUM_TIMER*TW-1:0] tmr_val,
	input wire logic [ECM_NUM_TIMER-1:0] tmr_cnt_stb,
	input wire logic [ECM_NUM_TIMER-1:0] tmr_load_stb,
	input wire logic [ECM_NUM_TIMER-1:0] tmr_clr_stb,
	input wire logic [NUM_CHAN-1:0] ch_en,
	input wire logic [NUM_CHAN-1:0] ch_cap_mode,
	input wire logic [NUM_CHAN-1:0] ch_tsel,
	input wire logic [NUM_CHAN*TW-1:0] ch_cmp,
	// events and pins
	input wire logic [NUM_CHAN-1:0] match_ff,
	input wire logic [NUM_CHAN-1:0] swt_evt_ff,
	input wire logic adc_start_ff,
	input wire logic [ECM_NUM_TIMER-1:0] tmr_rst_ff,
	input wire logic [NUM_CHAN-1:0] pin_ff,
	input wire logic [NUM_CHAN-1:0] cap_evt_ff
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// only a true count step may hit, never a load or a clear
	wire logic hit0 = ch_en[0] && !ch_cap_mode[0] && !ch_tsel[0] && tmr_cnt_stb[0] && !tmr_load_stb[0]
		&& !tmr_clr_stb[0] && tmr_val[TW-1:0] == ch_cmp[TW-1:0];
	sequence s_step_in;
		hit0 ##1 !match_ff[0];
	endsequence
	a_match_on_step: assert property (s_step_in |=> match_ff[0]) else $error("count match lost");
	a_match_cause: assert property (match_ff[0] |-> $past(hit0, 2)) else $error("match without step");
	a_match_pulse: assert property (match_ff[0] |=> !match_ff[0]) else $error("match too long");
	a_swt_cause: assert property ((swt_evt_ff & ~match_ff) == '0) else $error("stray timer event");
	a_adc_cause: assert property (adc_start_ff |-> |match_ff) else $error("stray start");
	a_rst_cause: assert property (|tmr_rst_ff |-> |match_ff) else $error("stray timer reset");
	a_pin_cause: assert property (((pin_ff ^ $past(pin_ff)) & ~match_ff) == '0) else $error("stray toggle");
	a_pins_gone: assert property (VARIANT == ECM_PINS_REMOVED |-> pin_ff[7:4] == 4'h0) else $error("pin driven");
	a_cap_gone: assert property (VARIANT == ECM_CAN |-> cap_evt_ff[7:4] == 4'h0) else $error("upper capture");
endmodule : ecm_checker
bind ecm_top ecm_checker #(.NUM_CHAN(NUM_CHAN), .TW(TW), .VARIANT(VARIANT)) ecm_checker_inst (.*);
`default_nettype wire

// File: testbench/ecm_timer_model.sv
// pair of up/down timers beside the channel array
`timescale 1ns/10ps
`default_nettype none
module ecm_timer_model
	import ecm_pkg::*;
(
	// clock
	input wire logic clk,
	// reset requests from the array
	input wire logic [ECM_NUM_TIMER-1:0] tmr_rst_ff,
	// timer state and strobes
	output logic [ECM_NUM_TIMER*ECM_TIMER_W-1:0] tmr_val = '0,
	output logic [ECM_NUM_TIMER-1:0] tmr_cnt_stb = '0,
	output logic [ECM_NUM_TIMER-1:0] tmr_load_stb = '0,
	output logic [ECM_NUM_TIMER-1:0] tmr_clr_stb = '0
);
	logic go = 1'b0;
	int t_q;
	logic [1:0] k_q;
	logic [15:0] v_q;
	always @(posedge clk) begin
		tmr_cnt_stb <= '0;
		tmr_load_stb <= '0;
		tmr_clr_stb <= tmr_rst_ff;
		for (int t = 0; t < ECM_NUM_TIMER; t++)
			if (tmr_rst_ff[t]) tmr_val[t*16+:16] <= 16'h0000;
		// software never writes a timer while its reset is pending
		if (go) begin
			tmr_cnt_stb[t_q] <= k_q != 2'h3;
			tmr_load_stb[t_q] <= k_q == 2'h3;
			tmr_val[t_q*16+:16] <= k_q == 2'h3 ? v_q : tmr_val[t_q*16+:16] + (k_q == 2'h1 ? 16'h0001 : 16'hFFFF);
		end
		go <= 1'b0;
	end
	// k: 1 up, 2 down, 3 load
	task automatic op(input int t, input logic [1:0] k, input logic [15:0] v);
		@(negedge clk);
		t_q = t;
		k_q = k;
		v_q = v;
		go = 1'b1;
		@(posedge clk);
		#1;
	endtask : op
endmodule : ecm_timer_model
`default_nettype wire

// File: testbench/ecm_top_tb.sv
// bench running all four die variants side by side
`timescale 1ns/10ps
`default_nettype none
module ecm_top_tb;
	import ecm_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] ch_en = 8'hFF;
	logic [7:0] cap_pin = 8'h00;
	logic [7:0] ch_tsel = 8'h00;
	logic [7:0] act_rst_tsel = 8'h00;
	logic [7:0] act_tog = 8'h11;
	logic [127:0] cv [4];
	logic [31:0] tmr_val;
	logic [1:0] tmr_cnt_stb, tmr_load_stb, tmr_clr_stb;
	logic [7:0] mt [4], sw [4], pn [4], ce [4];
	logic [7:0] seen [4] = '{default: 8'h00};
	logic ad [4];
	logic [1:0] tr [4];
	int n_fail = 0, checks_done = 0, cyc = 0;
	ecm_timer_model ecm_timer_model_inst (.clk, .tmr_rst_ff(tr[1]), .tmr_val, .tmr_cnt_stb, .tmr_load_stb,
		.tmr_clr_stb);
	for (genvar v = 0; v < 4; v++) begin : g_var
		ecm_top #(.VARIANT(ecm_variant_t'(v))) ecm_top_inst (.clk, .rst, .tmr_val, .tmr_cnt_stb, .tmr_load_stb,
			.tmr_clr_stb, .ch_en, .ch_cap_mode(8'h88), .ch_tsel,
			.ch_cmp(128'h0008_0007_0006_0005_0004_0000_0002_0001), .act_swt(8'h10), .act_adc(8'h20),
			.act_rst(8'h40), .act_rst_tsel, .act_tog, .cap_pin, .match_ff(mt[v]),
			.swt_evt_ff(sw[v]), .adc_start_ff(ad[v]), .tmr_rst_ff(tr[v]), .pin_ff(pn[v]), .cap_evt_ff(ce[v]),
			.cap_val_ff(cv[v]));
	end
	initial forever #10 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (!rst) begin
			for (int v = 0; v < 4; v++) seen[v] <= seen[v] | ce[v];
		end
		if (cyc == 3000) begin
			n_fail++;
			complete_run();
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %0t %s", $time, msg);
		end
	endtask : chk
	// match shows two edges after the strobe edge and stands one cycle
	task automatic step(input logic [1:0] k, input logic [15:0] v, input logic [7:0] exp);
		ecm_timer_model_inst.op(0, k, v);
		repeat (2) @(posedge clk);
		#1;
		chk(mt[1], exp, "match set");
	endtask : step
	task automatic t_count;
		step(2'h3, 16'h0005, 8'h00);
		step(2'h2, 16'h0000, 8'h00);
		step(2'h1, 16'h0000, 8'h10);
		chk(sw[3], 8'h10, "timer event");
		chk({5'h00, pn[1][4], pn[2][4], pn[3][4]}, 8'h05, "pin toggle");
		step(2'h1, 16'h0000, 8'h20);
		chk({7'h00, ad[3]}, 8'h01, "start");
		step(2'h1, 16'h0000, 8'h40);
		chk({6'h00, tr[3]}, 8'h01, "timer reset");
		repeat (4) begin
			@(posedge clk);
			#1;
			chk(mt[1], 8'h00, "zero hit");
		end
		step(2'h1, 16'h0000, 8'h01);
		step(2'h2, 16'h0000, 8'h04);
		$display("count test done");
	endtask : t_count
	task automatic t_timer1;
		@(posedge clk);
		ch_tsel <= 8'h40;
		act_rst_tsel <= 8'h40;
		act_tog <= 8'h51;
		ecm_timer_model_inst.op(1, 2'h3, 16'h0006);
		ecm_timer_model_inst.op(1, 2'h1, 16'h0000);
		repeat (2) @(posedge clk);
		#1;
		chk(mt[1], 8'h40, "timer one match");
		chk({6'h00, tr[3]}, 8'h02, "timer one reset");
		chk({6'h00, pn[1][6], pn[2][6]}, 8'h02, "upper toggle");
		$display("timer one test done");
	endtask : t_timer1
	task automatic t_capture;
		ecm_timer_model_inst.op(0, 2'h3, 16'h0033);
		@(posedge clk);
		cap_pin <= 8'h88;
		repeat (8) @(posedge clk);
		cap_pin <= 8'h00;
		#1;
		chk(seen[0], 8'h88, "full capture");
		chk(seen[1], 8'h88, "internal pins capture");
		chk(seen[3], 8'h08, "compare only");
		chk(seen[2], 8'h08, "pins removed");
		chk(cv[0][55:48], 8'h33, "captured value");
		chk(cv[0][119:112], 8'h33, "upper captured value");
		chk(cv[3][119:112], 8'h00, "no upper capture value");
		$display("capture test done");
	endtask : t_capture
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : complete_run
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_count();
		t_timer1();
		t_capture();
		complete_run();
	end
endmodule : ecm_top_tb
`default_nettype wire

// File: verilog/ecm_chan_if.sv
// signal bundle between the array top and one channel
`timescale 1ns/10ps
`default_nettype none
interface ecm_chan_if #(parameter int TW = 16);
	logic en;
	logic cap_mode;
	logic [TW-1:0] cmp_val;
	logic [TW-1:0] tmr_val;
	logic step;
	logic cap_edge;
	logic cap_allowed;
	logic match;
	logic cap_evt;
	logic [TW-1:0] cap_val;

	modport mp_top (
		output en, cap_mode, cmp_val, tmr_val, step, cap_edge, cap_allowed,
		input match, cap_evt, cap_val
	);
	modport mp_chan (
		input en, cap_mode, cmp_val, tmr_val, step, cap_edge, cap_allowed,
		output match, cap_evt, cap_val
	);
endinterface : ecm_chan_if
`default_nettype wire

// File: verilog/ecm_channel.sv
// one compare/capture channel
`timescale 1ns/10ps
`default_nettype none
module ecm_channel
	import ecm_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// link to array top
	ecm_chan_if.mp_chan ch
);
	logic match_ff;
	logic cap_evt_ff;
	logic [$bits(ch.cap_val)-1:0] cap_val_ff;

	// ****************************************
	// compare and capture
	// ****************************************
	// only a count step is looked at, so loads and clears never match
	wire hit = ch.en & ~ch.cap_mode & ch.step & (ch.tmr_val == ch.cmp_val);
	wire cap_take = ch.en & ch.cap_mode & ch.cap_allowed & ch.cap_edge;

	always_ff @(posedge clk) begin
		if (rst) begin
			match_ff <= 1'b0;
			cap_evt_ff <= 1'b0;
			cap_val_ff <= ECM_CAP_RST;
		end else begin
			match_ff <= hit;
			cap_evt_ff <= cap_take;
			if (cap_take) begin
				cap_val_ff <= ch.tmr_val;
			end
		end
	end

	assign ch.match = match_ff;
	assign ch.cap_evt = cap_evt_ff;
	assign ch.cap_val = cap_val_ff;
endmodule : ecm_channel
`default_nettype wire

// File: verilog/ecm_pkg.sv
// constants and types shared by the compare-match channel array
package ecm_pkg;
	// ****************************************
	// array shape
	// ****************************************
	localparam int ECM_NUM_CHAN = 8;
	localparam int ECM_NUM_TIMER = 2;
	localparam int ECM_TIMER_W = 16;
	localparam int ECM_UPPER_FIRST = 4;
	localparam int ECM_UPPER_LAST = 7;
	localparam logic [ECM_TIMER_W-1:0] ECM_CAP_RST = 16'h0000;

	// ****************************************
	// die variants
	// ****************************************
	typedef enum logic [1:0] {
		ECM_FULL,
		ECM_PINS_INTERNAL,
		ECM_PINS_REMOVED,
		ECM_CAN
	} ecm_variant_t;
endpackage : ecm_pkg

// File: verilog/ecm_top.sv
// compare-match channel array with timer, converter and pin actions
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - upper channels four to seven always present
// - pinless channels keep timer, converter, reset actions
// - internal-pin variant still toggles pin internally
// - pin-removed variant: upper channels drive no pins
// - CAN variant: upper channels compare only
// - match only when timer counts into value
// - loading timer to compare value gives nothing
// - clearing timer to zero gives nothing
module ecm_top
	import ecm_pkg::*;
#(
	parameter int NUM_CHAN = ECM_NUM_CHAN,
	parameter int TW = ECM_TIMER_W,
	parameter ecm_variant_t VARIANT = ECM_FULL
)(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// timers: value is the value after this cycle's event
	input wire logic [ECM_NUM_TIMER*TW-1:0] tmr_val,
	input wire logic [ECM_NUM_TIMER-1:0] tmr_cnt_stb,
	input wire logic [ECM_NUM_TIMER-1:0] tmr_load_stb,
	input wire logic [ECM_NUM_TIMER-1:0] tmr_clr_stb,
	// channel configuration
	input wire logic [NUM_CHAN-1:0] ch_en,
	input wire logic [NUM_CHAN-1:0] ch_cap_mode,
	input wire logic [NUM_CHAN-1:0] ch_tsel,
	input wire logic [NUM_CHAN*TW-1:0] ch_cmp,
	input wire logic [NUM_CHAN-1:0] act_swt,
	input wire logic [NUM_CHAN-1:0] act_adc,
	input wire logic [NUM_CHAN-1:0] act_rst,
	input wire logic [NUM_CHAN-1:0] act_rst_tsel,
	input wire logic [NUM_CHAN-1:0] act_tog,
	// capture pins, asynchronous
	input wire logic [NUM_CHAN-1:0] cap_pin,
	// events and pins
	output logic [NUM_CHAN-1:0] match_ff,
	output logic [NUM_CHAN-1:0] swt_evt_ff,
	output logic adc_start_ff,
	output logic [ECM_NUM_TIMER-1:0] tmr_rst_ff,
	output logic [NUM_CHAN-1:0] pin_ff,
	output logic [NUM_CHAN-1:0] cap_evt_ff,
	output logic [NUM_CHAN*TW-1:0] cap_val_ff
);
	// ****************************************
	// elaboration checks
	// ****************************************
	// channel count is fixed by the upper range and the pin map
	if (NUM_CHAN != ECM_NUM_CHAN) begin : g_bad_chan
		$error("channel count must be eight");
	end
	if (TW < 2) begin : g_bad_tw
		$error("timer width too small");
	end
	// the channel resets its capture register from a timer-width constant
	if (TW != ECM_TIMER_W) begin : g_bad_tw_match
		$error("timer width must match the timer pair");
	end
	// timer pick and reset routing assume a pair of timers
	if (ECM_NUM_TIMER != 2) begin : g_bad_tmr
		$error("exactly two timers are supported");
	end
	// pinless behaviour only makes sense inside the array
	if (ECM_UPPER_FIRST > ECM_UPPER_LAST || ECM_UPPER_LAST >= NUM_CHAN) begin : g_bad_upper
		$error("upper channel range outside the array");
	end

	function automatic logic is_upper(input int idx);
		return (idx >= ECM_UPPER_FIRST) && (idx <= ECM_UPPER_LAST);
	endfunction : is_upper

	function automatic logic [TW-1:0] tmr_pick(input logic sel, input logic [ECM_NUM_TIMER*TW-1:0] v);
		return sel ? v[2*TW-1:TW] : v[TW-1:0];
	endfunction : tmr_pick

	// a reset action goes to the timer named by that channel's reset select
	function automatic logic rst_hits(input logic [NUM_CHAN-1:0] req, input logic [NUM_CHAN-1:0] tsel,
		input logic t);
		return |(req & (t ? tsel : ~tsel));
	endfunction : rst_hits

	// ****************************************
	// die variant decode
	// ****************************************
	// only the optimized die lost the upper pin logic
	localparam logic UPPER_PINS_GONE = (VARIANT == ECM_PINS_REMOVED);
	// upper capture needs a pin path that these dies lack
	localparam logic UPPER_CAP_GONE = (VARIANT == ECM_CAN) || (VARIANT == ECM_PINS_REMOVED);

	// ****************************************
	// capture pin synchronisers
	// ****************************************
	logic [NUM_CHAN-1:0] cap_s1_ff;
	logic [NUM_CHAN-1:0] cap_s2_ff;
	logic [NUM_CHAN-1:0] cap_s3_ff;

	always_ff @(posedge clk) begin
		if (rst) begin
			cap_s1_ff <= '0;
			cap_s2_ff <= '0;
			cap_s3_ff <= '0;
		end else begin
			cap_s1_ff <= cap_pin;
			cap_s2_ff <= cap_s1_ff;
			cap_s3_ff <= cap_s2_ff;
		end
	end

	// third flop only remembers the last level; logic reads the second
	wire [NUM_CHAN-1:0] cap_rise = cap_s2_ff & ~cap_s3_ff;

	// ****************************************
	// timer step qualification
	// ****************************************
	// a load or clear in the same cycle wins over the count
	wire [ECM_NUM_TIMER-1:0] tmr_step = tmr_cnt_stb & ~tmr_load_stb & ~tmr_clr_stb;

	// ****************************************
	// channel array
	// ****************************************
	wire [NUM_CHAN-1:0] ch_match;
	wire [NUM_CHAN-1:0] ch_cap_evt;
	wire [NUM_CHAN*TW-1:0] ch_cap_val;
	wire [NUM_CHAN-1:0] pin_kept;

	for (genvar i = 0; i < NUM_CHAN; i++) begin : g_ch
		ecm_chan_if #(.TW(TW)) ch_if ();
		// every channel is built, pins or not
		ecm_channel u_chan (
			.clk(clk),
			.rst(rst),
			.ch(ch_if.mp_chan)
		);
		// capture needs a bonded pin; the CAN and pin-removed dies have none upstairs
		localparam logic CAP_OK = !(is_upper(i) && UPPER_CAP_GONE);
		// pin logic exists unless the optimized die dropped it
		assign pin_kept[i] = !(is_upper(i) && UPPER_PINS_GONE);
		assign ch_if.en = ch_en[i];
		assign ch_if.cap_mode = ch_cap_mode[i];
		assign ch_if.cmp_val = ch_cmp[i*TW +: TW];
		assign ch_if.tmr_val = tmr_pick(ch_tsel[i], tmr_val);
		// the timer select also picks which strobe counts as a step
		assign ch_if.step = tmr_step[ch_tsel[i]];
		assign ch_if.cap_edge = cap_rise[i];
		assign ch_if.cap_allowed = CAP_OK;
		assign ch_match[i] = ch_if.match;
		assign ch_cap_evt[i] = ch_if.cap_evt;
		assign ch_cap_val[i*TW +: TW] = ch_if.cap_val;
	end

	// ****************************************
	// match actions
	// ****************************************
	wire [NUM_CHAN-1:0] nxt_swt = ch_match & act_swt;
	wire nxt_adc = |(ch_match & act_adc);

	// ****************************************
	// timer reset routing
	// ****************************************
	wire [NUM_CHAN-1:0] rst_req = ch_match & act_rst;
	// hazard: a software write racing this reset is undefined upstream
	wire [ECM_NUM_TIMER-1:0] nxt_tmr_rst = {rst_hits(rst_req, act_rst_tsel, 1'b1),
		rst_hits(rst_req, act_rst_tsel, 1'b0)};
	wire [NUM_CHAN-1:0] nxt_pin = (pin_ff ^ (ch_match & act_tog)) & pin_kept;

	// ****************************************
	// match event registers
	// ****************************************
	// one-cycle pulses: a channel never matches on two steps in a row
	always_ff @(posedge clk) begin
		if (rst) begin
			match_ff <= '0;
			swt_evt_ff <= '0;
		end else begin
			match_ff <= ch_match;
			swt_evt_ff <= nxt_swt;
		end
	end

	// ****************************************
	// converter start and timer reset requests
	// ****************************************
	// both are wide ORs, so a register keeps them off the compare path
	always_ff @(posedge clk) begin
		if (rst) begin
			adc_start_ff <= 1'b0;
			tmr_rst_ff <= '0;
		end else begin
			adc_start_ff <= nxt_adc;
			tmr_rst_ff <= nxt_tmr_rst;
		end
	end

	// ****************************************
	// port pin state
	// ****************************************
	// removed pins stay low here; their read-back is handled outside
	always_ff @(posedge clk) begin
		if (rst) begin
			pin_ff <= '0;
		end else begin
			pin_ff <= nxt_pin;
		end
	end

	// ****************************************
	// capture results
	// ****************************************
	// the value holds because each channel only updates it on a capture
	always_ff @(posedge clk) begin
		if (rst) begin
			cap_evt_ff <= '0;
			cap_val_ff <= '0;
		end else begin
			cap_evt_ff <= ch_cap_evt;
			cap_val_ff <= ch_cap_val;
		end
	end
endmodule : ecm_top
`default_nettype wire
